// file: core/ltm_transceiver.sv
// Behaviour
// - Start off; off ignores bus wakes
// - Normal mode only in Normal/Stop
// - Normal mode copies tx and rx
// - Early dominant dropped; next one sent
// - Receive-only: driver off, rx delivered
// - Wake mode selectable; forced in fail-safe
// - Wake: long dominant then rising edge
// - Wake dominant time 30 to 150 us
// - Wake holds rx low until an accepted non-wake mode write
// - Wake response depends on power mode
// - Mode still reads wake code after wake
// - Rearm by toggling mode then wake
// - Rearm on Stop, Sleep, Fail-Safe entry
// - Normal/Stop wake: interrupt, status, rx low
// - Stop wake enables watchdog if option set
// - Sleep/fail-safe wake: restart, no interrupt
// - Tx timeout disables driver, sets fault
// - Bus dominant timeout sets fault
// - Undervoltage disables driver and receiver
// - Default normal slope; bit selects low
// - Slope applies at select rise, Normal only
// - Flash bit disables slope control; not done here, o_flash and o_low_slope are set independently
module ltm_transceiver
    import ltm_pkg::*;
#(
    parameter int unsigned TXTO_CYCLES  = LTM_TXTO_CYCLES,
    parameter int unsigned BUSTO_CYCLES = LTM_BUSTO_CYCLES,
    parameter int unsigned WAKE_CYCLES  = LTM_WAKE_CYCLES
) (
    input  wire logic          i_ref_clk,
    input  wire logic          i_rst_n,
    input  wire ltm_cmd_type   i_cmd,               // Software command
    input  wire logic          i_spi_select_n,      // Chip select
    input  wire ltm_pmode_type i_pmode,             // Current power mode
    input  wire logic          i_watchdog_on_bus_wake,
    input  wire logic          i_watchdog_enabled,
    input  wire logic          i_supply_uv,         // Supply below threshold
    input  wire logic          i_bus_tx_input,      // From controller, 0 dominant
    input  wire logic          i_bus_level,         // Received bus level
    output logic               o_bus_drive_low,     // Driver pulls bus dominant
    output logic               o_bus_rx_output,     // To controller
    output ltm_mode_type       o_mode,              // Mode readback
    output logic               o_low_slope,
    output logic               o_flash,
    output logic               o_fail,              // Sticky fault flag
    output logic               o_wake_source_status,
    output logic               o_interrupt_out_n,
    output logic               o_restart_req,       // Pulse: go to Restart
    output logic               o_watchdog_enable    // Pulse: enable watchdog
);
    // Reset release through two flops
    logic rst_s1;
    logic rst_n;
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    // Count saturating at a limit
    function automatic logic [LTM_CNT_W-1:0] sat_inc(input logic [LTM_CNT_W-1:0] c, input int unsigned lim);
        sat_inc = (c >= LTM_CNT_W'(lim)) ? c : c + LTM_CNT_W'(1);
    endfunction

    ltm_mode_type          mode, next_mode;
    logic                  low_slope, next_low_slope;
    logic                  flash, next_flash;
    logic                  fail, next_fail;
    logic                  wake_source_status, next_wake_source_status;
    logic                  armed, next_armed;       // Wake detection armed
    logic                  woke, next_woke;         // Rx held low after wake
    logic                  int_n, next_int_n;
    logic                  restart, next_restart;
    logic                  wd_en, next_wd_en;
    logic                  sel_q;                   // Select delayed for edge
    logic                  pend_slope, next_pend_slope;
    logic                  pend_flash, next_pend_flash;
    ltm_pmode_type         pm_q;                    // Previous power mode
    ltm_wk_state_type      wk, next_wk;
    logic [LTM_CNT_W-1:0]  wk_cnt, next_wk_cnt;
    logic [LTM_CNT_W-1:0]  tx_cnt, next_tx_cnt;
    logic [LTM_CNT_W-1:0]  bus_cnt, next_bus_cnt;
    logic [LTM_CNT_W-1:0]  en_cnt, next_en_cnt;
    logic                  tx_block, next_tx_block; // Dominant seen before enable done
    logic                  tx_to, next_tx_to;       // Timeout latched until recessive
    logic                  drive, next_drive;
    logic                  rx, next_rx;

    logic pm_nrm_stop;
    logic wake_evt;
    logic sel_rise;
    logic pm_enter;
    assign pm_nrm_stop = (i_pmode == LTM_PM_NORMAL) || (i_pmode == LTM_PM_STOP);
    assign sel_rise    = i_spi_select_n && !sel_q;
    // Entry into a power mode that rearms wake detection
    assign pm_enter    = (i_pmode != pm_q) && (i_pmode == LTM_PM_STOP || i_pmode == LTM_PM_SLEEP
                         || i_pmode == LTM_PM_FAILSAFE);
    // Mode is checked again here: a mode write on the edge that entered QUAL must not let a wake through
    assign wake_evt    = (wk == LTM_WK_QUAL) && i_bus_level && (mode == LTM_WAKE);

    // Wake detector: falling edge, long dominant, then rising edge
    always_comb begin
        next_wk     = wk;
        next_wk_cnt = wk_cnt;
        case (wk)
            LTM_WK_IDLE: begin
                next_wk_cnt = '0;
                if (mode == LTM_WAKE && armed && !i_supply_uv && i_bus_level) begin
                    next_wk = LTM_WK_DONE;
                end
            end
            LTM_WK_DONE: begin          // Recessive seen, wait for falling edge
                next_wk_cnt = '0;
                if (mode != LTM_WAKE || !armed) begin
                    next_wk = LTM_WK_IDLE;
                end else if (!i_bus_level) begin
                    next_wk = LTM_WK_LOW;
                end
            end
            LTM_WK_LOW: begin
                next_wk_cnt = sat_inc(wk_cnt, WAKE_CYCLES);
                if (mode != LTM_WAKE || !armed) begin
                    next_wk = LTM_WK_IDLE;
                end else if (i_bus_level) begin
                    next_wk = LTM_WK_DONE;  // Too short, ignore
                end else if (wk_cnt >= LTM_CNT_W'(WAKE_CYCLES)) begin
                    next_wk = LTM_WK_QUAL;
                end
            end
            LTM_WK_QUAL: begin
                if (i_bus_level || mode != LTM_WAKE) begin
                    next_wk = LTM_WK_IDLE;
                end
            end
            default: next_wk = LTM_WK_IDLE;
        endcase
    end

    // Mode, configuration, wake response and fault state
    always_comb begin
        next_mode       = mode;
        next_low_slope  = low_slope;
        next_flash      = flash;
        next_fail       = fail;
        next_wake_source_status    = wake_source_status;
        next_armed      = armed;
        next_woke       = woke;
        next_int_n      = 1'b1;
        next_restart    = 1'b0;
        next_wd_en      = 1'b0;
        next_pend_slope = pend_slope;
        next_pend_flash = pend_flash;
        if (i_cmd.write) begin
            // Normal and receive-only only in Normal/Stop; wake not in fail-safe
            if (((i_cmd.mode == LTM_NORMAL || i_cmd.mode == LTM_RXONLY) && pm_nrm_stop)
                || (i_cmd.mode == LTM_WAKE && i_pmode != LTM_PM_FAILSAFE)
                || i_cmd.mode == LTM_OFF) begin
                next_mode = i_cmd.mode;
                if (i_cmd.mode != LTM_WAKE) begin
                    next_woke  = 1'b0;
                    next_armed = 1'b1;
                end
            end
            if (i_pmode == LTM_PM_NORMAL) begin
                next_pend_slope = i_cmd.low_slope;
                next_pend_flash = i_cmd.flash;
            end
            if (i_cmd.clear_fail) begin
                next_fail = 1'b0;
            end
        end
        if (sel_rise) begin
            next_low_slope = pend_slope;
            next_flash     = pend_flash;
        end
        if (i_pmode == LTM_PM_FAILSAFE) begin
            next_mode = LTM_WAKE;
        end
        if (pm_enter) begin
            next_armed = 1'b1;
        end
        if (wake_evt) begin             // Mode stays wake code
            next_woke    = 1'b1;
            next_armed   = 1'b0;
            next_wake_source_status = 1'b1;
            if (pm_nrm_stop) begin
                next_int_n = 1'b0;
                if (i_pmode == LTM_PM_STOP && i_watchdog_on_bus_wake && !i_watchdog_enabled) begin
                    next_wd_en = 1'b1;
                end
            end else begin
                next_restart = 1'b1;
            end
        end
        // Set wins over a clear in the same cycle
        if ((tx_cnt >= LTM_CNT_W'(TXTO_CYCLES)) || (bus_cnt >= LTM_CNT_W'(BUSTO_CYCLES))) begin
            next_fail = 1'b1;
        end
    end

    // Datapath: enable time, tx timeout, bus clamp, undervoltage
    always_comb begin
        next_en_cnt   = (mode == LTM_NORMAL) ? sat_inc(en_cnt, LTM_EN_CYCLES) : '0;
        next_tx_cnt   = i_bus_tx_input ? '0 : sat_inc(tx_cnt, TXTO_CYCLES);
        next_bus_cnt  = (!i_bus_level && (mode == LTM_NORMAL || mode == LTM_RXONLY) && !i_supply_uv)
                        ? sat_inc(bus_cnt, BUSTO_CYCLES) : '0;
        next_tx_to    = i_bus_tx_input ? 1'b0 : (tx_to || tx_cnt >= LTM_CNT_W'(TXTO_CYCLES));
        next_tx_block = tx_block;
        if (mode != LTM_NORMAL) begin
            next_tx_block = 1'b0;
        end else if (en_cnt < LTM_CNT_W'(LTM_EN_CYCLES) && !i_bus_tx_input) begin
            next_tx_block = 1'b1;
        end else if (i_bus_tx_input) begin
            next_tx_block = 1'b0;
        end
        next_drive = (mode == LTM_NORMAL) && !i_bus_tx_input && !i_supply_uv
                     && en_cnt >= LTM_CNT_W'(LTM_EN_CYCLES) && !tx_block && !next_tx_to;
        if (woke) begin
            next_rx = 1'b0;
        end else if ((mode == LTM_NORMAL || mode == LTM_RXONLY) && !i_supply_uv) begin
            next_rx = i_bus_level;
        end else begin
            next_rx = 1'b1;
        end
    end

    // Register all state
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode       <= LTM_MODE_RST;
            low_slope  <= 1'b0;
            flash      <= 1'b0;
            fail       <= 1'b0;
            wake_source_status    <= 1'b0;
            armed      <= 1'b1;
            woke       <= 1'b0;
            int_n      <= 1'b1;
            restart    <= 1'b0;
            wd_en      <= 1'b0;
            sel_q      <= 1'b1;
            pend_slope <= 1'b0;
            pend_flash <= 1'b0;
            pm_q       <= LTM_PM_NORMAL;
            wk         <= LTM_WK_IDLE;
            wk_cnt     <= '0;
            tx_cnt     <= '0;
            bus_cnt    <= '0;
            en_cnt     <= '0;
            tx_block   <= 1'b0;
            tx_to      <= 1'b0;
            drive      <= 1'b0;
            rx         <= 1'b1;
        end else begin
            mode       <= next_mode;
            low_slope  <= next_low_slope;
            flash      <= next_flash;
            fail       <= next_fail;
            wake_source_status    <= next_wake_source_status;
            armed      <= next_armed;
            woke       <= next_woke;
            int_n      <= next_int_n;
            restart    <= next_restart;
            wd_en      <= next_wd_en;
            sel_q      <= i_spi_select_n;
            pend_slope <= next_pend_slope;
            pend_flash <= next_pend_flash;
            pm_q       <= i_pmode;
            wk         <= next_wk;
            wk_cnt     <= next_wk_cnt;
            tx_cnt     <= next_tx_cnt;
            bus_cnt    <= next_bus_cnt;
            en_cnt     <= next_en_cnt;
            tx_block   <= next_tx_block;
            tx_to      <= next_tx_to;
            drive      <= next_drive;
            rx         <= next_rx;
        end
    end

    // Outputs straight from flops; wake status clears only by reset here
    assign o_bus_drive_low      = drive;
    assign o_bus_rx_output      = rx;
    assign o_mode               = mode;
    assign o_low_slope          = low_slope;
    assign o_flash              = flash;
    assign o_fail               = fail;
    assign o_wake_source_status = wake_source_status;
    assign o_interrupt_out_n    = int_n;
    assign o_restart_req        = restart;
    assign o_watchdog_enable    = wd_en;

    // Checks
    wake_rx_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        wake_evt |=> ##1 !o_bus_rx_output) else $error("rx not low after wake");
    off_nowake_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        (mode == LTM_OFF) |=> o_interrupt_out_n && !o_restart_req && $stable(o_wake_source_status))
        else $error("wake in off mode");
    mode_keep_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        (wake_evt && !i_cmd.write && i_pmode != LTM_PM_FAILSAFE) |=> (o_mode == LTM_WAKE))
        else $error("mode changed by wake");
    int_stop_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        (wake_evt && pm_nrm_stop) |=> !o_interrupt_out_n && o_wake_source_status) else $error("no interrupt");
    int_sleep_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        (wake_evt && !pm_nrm_stop) |=> o_interrupt_out_n && o_restart_req) else $error("bad sleep wake");
    drive_uv_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        i_supply_uv |=> !o_bus_drive_low) else $error("driving in undervoltage");
    drive_mode_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        (mode != LTM_NORMAL) |=> !o_bus_drive_low) else $error("driving outside normal");
    fail_hold_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        (o_fail && !(i_cmd.write && i_cmd.clear_fail)) |=> o_fail) else $error("fault lost");

    // Dominant request while the enable time still runs
    sequence early_dom_s;
        (mode == LTM_NORMAL) && (en_cnt < LTM_CNT_W'(LTM_EN_CYCLES)) && !i_bus_tx_input;
    endsequence
    // Transmit input held dominant past the time-out
    sequence tx_stuck_s;
        !i_bus_tx_input && (tx_cnt >= LTM_CNT_W'(TXTO_CYCLES));
    endsequence
    early_block_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        early_dom_s ##1 !i_bus_tx_input |=> !o_bus_drive_low) else $error("early dominant sent");
    tx_timeout_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        tx_stuck_s |=> !o_bus_drive_low && o_fail) else $error("stuck tx still driven");
endmodule

// file: shared/ltm_pkg.sv
package ltm_pkg;
    // Transceiver mode codes as software writes them
    typedef enum logic [1:0] {
        LTM_OFF     = 2'h0,
        LTM_WAKE    = 2'h1,
        LTM_RXONLY  = 2'h2,
        LTM_NORMAL  = 2'h3
    } ltm_mode_type;

    // Device power modes, one-hot
    typedef enum logic [4:0] {
        LTM_PM_NORMAL   = 5'h01,
        LTM_PM_STOP     = 5'h02,
        LTM_PM_SLEEP    = 5'h04,
        LTM_PM_RESTART  = 5'h08,
        LTM_PM_FAILSAFE = 5'h10
    } ltm_pmode_type;

    // Wake detector states, one-hot
    typedef enum logic [3:0] {
        LTM_WK_IDLE  = 4'h1,
        LTM_WK_LOW   = 4'h2,
        LTM_WK_QUAL  = 4'h4,
        LTM_WK_DONE  = 4'h8
    } ltm_wk_state_type;

    // Software command bundle, taken on the write strobe; slope and flash apply at select rise
    typedef struct packed {
        logic         write;       // One-cycle write strobe
        ltm_mode_type mode;        // Requested transceiver mode
        logic         low_slope;   // Low slope request
        logic         flash;       // Flash mode request
        logic         clear_fail;  // Clear fault flag
    } ltm_cmd_type;

    localparam int          LTM_CLK_MHZ        = 200;
    // Wake qualifying time, window 30..150 us; 60 us chosen
    localparam int          LTM_WAKE_TIME_US   = 60;
    localparam int          LTM_WAKE_CYCLES    = LTM_WAKE_TIME_US * LTM_CLK_MHZ;
    localparam int          LTM_TXTO_TIME_US   = 20000;
    localparam int          LTM_TXTO_CYCLES    = LTM_TXTO_TIME_US * LTM_CLK_MHZ;
    localparam int          LTM_BUSTO_TIME_US  = 20000;
    localparam int          LTM_BUSTO_CYCLES   = LTM_BUSTO_TIME_US * LTM_CLK_MHZ;
    localparam int          LTM_EN_TIME_US     = 10;
    localparam int          LTM_EN_CYCLES      = LTM_EN_TIME_US * LTM_CLK_MHZ;
    localparam int          LTM_CNT_W          = 24;
    localparam ltm_mode_type LTM_MODE_RST      = LTM_OFF;
endpackage

// file: test/ltm_bus_node.sv
// Single-wire bus with the master pull-up; remote nodes are modelled as one requester
module ltm_bus_node (
    input  wire logic i_drive_low,   // Transceiver pulls the bus dominant
    input  wire logic i_remote_dom,  // Remote node drives dominant
    output logic      o_bus_level    // Bus level, 0 dominant
);
    timeunit 1ns;
    timeprecision 1ps;

    // Released bus floats up through the pull-up, so recessive is a real level, not a stale one
    always_comb begin
        o_bus_level = !(i_drive_low || i_remote_dom);
    end
endmodule

// file: test/tb_ltm_transceiver.sv
module tb_ltm_transceiver import ltm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TXTO  = 40;     // Shortened counts keep the run brief
    localparam int BUSTO = 60;
    localparam int WAKE  = 20;
    localparam int LIMIT = 40000;  // Cycle ceiling, well above the planned run
    logic          clk, rst_n, sel_n, wd_opt, wd_on, uv, tx, remote, bus;
    logic          drv, rx, ls, fl, fail, wks, int_n, rreq, wdp;
    ltm_cmd_type   cmd;
    ltm_pmode_type pmode;
    ltm_mode_type  mode;
    int            num_errors, check_count, n_int, n_rst, n_wd, cycles;

    ltm_transceiver #(.TXTO_CYCLES(TXTO), .BUSTO_CYCLES(BUSTO), .WAKE_CYCLES(WAKE)) uut (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_cmd(cmd), .i_spi_select_n(sel_n),
        .i_pmode(pmode), .i_watchdog_on_bus_wake(wd_opt), .i_watchdog_enabled(wd_on),
        .i_supply_uv(uv), .i_bus_tx_input(tx), .i_bus_level(bus), .o_bus_drive_low(drv),
        .o_bus_rx_output(rx), .o_mode(mode), .o_low_slope(ls), .o_flash(fl), .o_fail(fail),
        .o_wake_source_status(wks), .o_interrupt_out_n(int_n), .o_restart_req(rreq),
        .o_watchdog_enable(wdp));
    ltm_bus_node node (.i_drive_low(drv), .i_remote_dom(remote), .o_bus_level(bus));

    // Free-running reference clock
    always #2.5 clk = ~clk;

    task automatic give_verdict();
        $display("Checks made %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Pulses last one cycle, so count them at the falling edge where they are settled
    always @(negedge clk) begin
        n_int += (int_n === 1'b0);
        n_rst += (rreq === 1'b1);
        n_wd += (wdp === 1'b1);
        cycles++;
        if (cycles == LIMIT) begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // Wait n edges, then step past the last one so outputs are settled
    task automatic look(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Software write; select stays low so slope changes wait for cs_up
    task automatic wr(input ltm_mode_type m, input logic l, input logic f, input logic c);
        @(posedge clk);
        cmd <= '{1'b1, m, l, f, c};
        sel_n <= 1'b0;
        @(posedge clk);
        cmd.write <= 1'b0;
        look(1);
    endtask

    task automatic cs_up();
        @(posedge clk);
        sel_n <= 1'b1;
        look(2);
    endtask

    task automatic pm(input ltm_pmode_type p);
        @(posedge clk);
        pmode <= p;
        look(2);
    endtask

    // Controller transmit level and remote node request, held for n cycles
    task automatic lines(input logic t, input logic r, input int n);
        @(posedge clk);
        tx <= t;
        remote <= r;
        look(n);
    endtask

    // Dominant pulse from the far side, then recessive long enough to flag a wake
    task automatic dom(input int n);
        lines(1'b1, 1'b1, n);
        lines(1'b1, 1'b0, 4);
    endtask

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        sel_n = 1'b1;
        cmd = '0;
        pmode = LTM_PM_SLEEP;
        wd_opt = 1'b1;
        wd_on = 1'b0;
        uv = 1'b0;
        tx = 1'b1;
        remote = 1'b0;
        {num_errors, check_count, n_int, n_rst, n_wd, cycles} = '0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        look(3);
        chk("mode", mode, LTM_OFF);
        chk("rx", rx, 1'b1);
        chk("slope", ls, 1'b0);
        dom(WAKE + 5);
        chk("wake status", wks, 1'b0);
        chk("restart", n_rst, 0);
        wr(LTM_NORMAL, 0, 0, 0);
        chk("mode", mode, LTM_OFF);
        wr(LTM_RXONLY, 0, 0, 0);
        chk("mode", mode, LTM_OFF);
        // Slope and flash apply only at select rise, only in Normal
        pm(LTM_PM_NORMAL);
        wr(LTM_OFF, 1, 0, 0);
        chk("slope", ls, 1'b0);
        cs_up();
        chk("slope", ls, 1'b1);
        wr(LTM_OFF, 1, 1, 0);
        cs_up();
        chk("flash", fl, 1'b1);
        pm(LTM_PM_STOP);
        wr(LTM_OFF, 0, 0, 0);
        cs_up();
        chk("slope", ls, 1'b1);
        pm(LTM_PM_NORMAL);
        // Early dominant must not reach the bus
        wr(LTM_NORMAL, 0, 0, 0);
        chk("mode", mode, LTM_NORMAL);
        lines(1'b0, 1'b0, 5);
        chk("drive", drv, 1'b0);
        lines(1'b1, 1'b0, 2000);
        lines(1'b0, 1'b0, 2);
        chk("drive", drv, 1'b1);
        chk("rx", rx, 1'b0);
        lines(1'b1, 1'b0, 2);
        chk("rx", rx, 1'b1);
        // Undervoltage silences driver and receiver
        @(posedge clk);
        uv <= 1'b1;
        lines(1'b0, 1'b1, 3);
        chk("drive", drv, 1'b0);
        chk("rx", rx, 1'b1);
        @(posedge clk);
        uv <= 1'b0;
        lines(1'b1, 1'b0, 3);
        chk("mode", mode, LTM_NORMAL);
        // Stuck transmit input
        lines(1'b0, 1'b0, TXTO + 5);
        chk("drive", drv, 1'b0);
        chk("fail", fail, 1'b1);
        chk("mode", mode, LTM_NORMAL);
        lines(1'b1, 1'b0, 2);
        chk("fail", fail, 1'b1);
        lines(1'b0, 1'b0, 2);
        chk("drive", drv, 1'b1);
        lines(1'b1, 1'b0, 2);
        wr(LTM_RXONLY, 0, 0, 1);
        chk("fail", fail, 1'b0);
        // Receive-only keeps the driver off; clamped bus is a fault
        lines(1'b0, 1'b0, 3);
        chk("drive", drv, 1'b0);
        lines(1'b1, 1'b1, 3);
        chk("rx", rx, 1'b0);
        look(BUSTO);
        chk("fail", fail, 1'b1);
        chk("mode", mode, LTM_RXONLY);
        lines(1'b1, 1'b0, 2);
        // Wake in Normal power mode, then rearm by toggling
        wr(LTM_WAKE, 0, 0, 1);
        dom(WAKE + 5);
        chk("int count", n_int, 1);
        chk("wake status", wks, 1'b1);
        chk("rx", rx, 1'b0);
        chk("mode", mode, LTM_WAKE);
        chk("restart", n_rst, 0);
        dom(WAKE + 5);
        chk("int count", n_int, 1);
        wr(LTM_OFF, 0, 0, 0);
        chk("rx", rx, 1'b1);
        wr(LTM_WAKE, 0, 0, 0);
        dom(WAKE - 5);
        chk("int count", n_int, 1);
        dom(WAKE + 5);
        chk("int count", n_int, 2);
        // Power mode changes rearm detection
        pm(LTM_PM_STOP);
        dom(WAKE + 5);
        chk("int count", n_int, 3);
        chk("watchdog", n_wd, 1);
        // Watchdog already running: a Stop wake must not pulse the enable
        @(posedge clk);
        wd_on <= 1'b1;
        wr(LTM_OFF, 0, 0, 0);
        wr(LTM_WAKE, 0, 0, 0);
        dom(WAKE + 5);
        chk("int count", n_int, 4);
        chk("watchdog", n_wd, 1);
        // Release the held rx first so the Sleep wake shows its own low
        wr(LTM_OFF, 0, 0, 0);
        chk("rx", rx, 1'b1);
        wr(LTM_WAKE, 0, 0, 0);
        pm(LTM_PM_SLEEP);
        dom(WAKE + 5);
        chk("restart", n_rst, 1);
        chk("int count", n_int, 4);
        chk("rx", rx, 1'b0);
        chk("watchdog", n_wd, 1);
        wr(LTM_OFF, 0, 0, 0);
        pm(LTM_PM_FAILSAFE);
        chk("mode", mode, LTM_WAKE);
        dom(WAKE + 5);
        chk("restart", n_rst, 2);
        give_verdict();
    end
endmodule
